// ### hw/clsc_serializer.v
// Pixel serializer core: framing, clock fallback, CRC count, outputs
`timescale 1ns/100ps
`include "clsc_regs.vh"

module clsc_serializer #(
    parameter LOSS_NS = `CLSC_PCLK_LOSS_NS,
    parameter OSC_NS = `CLSC_OSC_FRAME_NS
) (
    input wire clk,
    input wire reset_n,
    input wire pixel_clock,
    input wire [11:0] pixel_data,
    input wire line_sync,
    input wire frame_sync,
    input wire power_down_n,
    input wire ext_osc_mode,
    input wire general_output_three_in,
    input wire ctrl_tx_bit,
    input wire bc_valid,
    input wire [7:0] bc_data,
    input wire [3:0] bc_crc,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata_q,
    output reg [27:0] frame_word_q,
    output reg frame_valid_q,
    output reg link_enable_q,
    output reg [3:0] general_output_pin_q,
    output reg [3:0] general_output_oe_q
);

// ----------------------------------------------------------------
// Derived counts
// ----------------------------------------------------------------
localparam LOSS_CYC = (LOSS_NS + `CLSC_CLK_PERIOD_NS - 1)
    / `CLSC_CLK_PERIOD_NS;
localparam OSC_CYC = OSC_NS / `CLSC_CLK_PERIOD_NS;
localparam [15:0] LOSS_MAX = LOSS_CYC[15:0];
localparam [15:0] OSC_MAX = OSC_CYC[15:0];

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
function [4:0] ones26;
    input [25:0] v;
    integer i;
    begin
        ones26 = 5'h00;
        for (i = 0; i < 26; i = i + 1) begin
            ones26 = ones26 + {4'h0, v[i]};
        end
    end
endfunction

function [3:0] crc4;
    input [7:0] d;
    integer i;
    reg [3:0] c;
    reg fb;
    begin
        c = 4'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
        end
        crc4 = c;
    end
endfunction

// ----------------------------------------------------------------
// Reset release and pin synchronisers
// ----------------------------------------------------------------
reg rst_s1_q, rst_n_q;
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        rst_s1_q <= 1'b0;
        rst_n_q <= 1'b0;
    end else begin
        rst_s1_q <= 1'b1;
        rst_n_q <= rst_s1_q;
    end
end

reg [17:0] pin_s1_q, pin_s2_q;
reg pclk_s3_q, xclk_s3_q;
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        pin_s1_q <= 18'h00000;
        pin_s2_q <= 18'h00000;
        pclk_s3_q <= 1'b0;
        xclk_s3_q <= 1'b0;
    end else begin
        pin_s1_q <= {general_output_three_in, ext_osc_mode, power_down_n,
            pixel_clock, frame_sync, line_sync, pixel_data};
        pin_s2_q <= pin_s1_q;
        pclk_s3_q <= pin_s2_q[14];
        xclk_s3_q <= pin_s2_q[17];
    end
end

wire pclk_s = pin_s2_q[14];
wire pd_active = ~pin_s2_q[15];
wire ext_mode = pin_s2_q[16];
wire xclk_rise = pin_s2_q[17] & ~xclk_s3_q;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] config_q;
reg [1:0] mode_q;
reg [7:0] gpo_cfg_q;
reg [15:0] crc_cnt_q;
reg on_pclk_q;
wire edge_sel = config_q[`CLSC_CFG_EDGE_BIT];
wire no_pclk = config_q[`CLSC_CFG_NO_PCLK_BIT];
wire clr_cnt = reg_write && (reg_addr == `CLSC_ADDR_CRC_CNT_FIRST ||
    reg_addr == `CLSC_ADDR_CRC_CNT_SECOND);

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        config_q <= `CLSC_CONFIG_RST;
        mode_q <= `CLSC_MODE_RST;
        gpo_cfg_q <= `CLSC_GPO_CFG_RST;
    end else if (reg_write) begin
        if (reg_addr == `CLSC_ADDR_CONFIG) begin
            config_q <= reg_wdata;
        end
        if (reg_addr == `CLSC_ADDR_MODE) begin
            mode_q <= reg_wdata[1:0];
        end
        if (reg_addr == `CLSC_ADDR_GPO_CFG) begin
            gpo_cfg_q <= reg_wdata;
        end
    end
end

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
        case (reg_addr)
            `CLSC_ADDR_CONFIG: reg_rdata_q <= config_q;
            `CLSC_ADDR_MODE: reg_rdata_q <= {6'h00, mode_q};
            `CLSC_ADDR_CRC_CNT_FIRST: reg_rdata_q <= crc_cnt_q[7:0];
            `CLSC_ADDR_CRC_CNT_SECOND: reg_rdata_q <= crc_cnt_q[15:8];
            `CLSC_ADDR_GPO_CFG: reg_rdata_q <= gpo_cfg_q;
            `CLSC_ADDR_STATUS: reg_rdata_q <= {5'h00, ext_mode,
                pd_active, on_pclk_q};
            default: reg_rdata_q <= 8'h00;
        endcase
    end else begin
        reg_rdata_q <= 8'h00;
    end
end

// ----------------------------------------------------------------
// Back channel CRC check and remote values
// ----------------------------------------------------------------
wire bc_bad = bc_valid && (crc4(bc_data) != bc_crc);
reg [3:0] remote_q;
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        crc_cnt_q <= 16'h0000;
        remote_q <= 4'h0;
    end else begin
        if (bc_bad) begin
            if (clr_cnt) begin
                crc_cnt_q <= 16'h0001;
            end else if (crc_cnt_q != 16'hFFFF) begin
                crc_cnt_q <= crc_cnt_q + 16'h0001;
            end
        end else if (clr_cnt) begin
            crc_cnt_q <= 16'h0000;
        end
        if (bc_valid && !bc_bad) begin
            remote_q <= bc_data[3:0];
        end
    end
end

// ----------------------------------------------------------------
// Pixel clock watch and internal oscillator fallback
// ----------------------------------------------------------------
wire p_rise = pclk_s & ~pclk_s3_q;
wire p_fall = ~pclk_s & pclk_s3_q;
wire p_edge = edge_sel ? p_rise : p_fall;
reg [15:0] loss_q;
reg [15:0] osc_q;
wire osc_tick = (osc_q == OSC_MAX - 16'h0001);

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        loss_q <= 16'h0000;
        osc_q <= 16'h0000;
        on_pclk_q <= 1'b0;
    end else begin
        osc_q <= osc_tick ? 16'h0000 : osc_q + 16'h0001;
        if (p_rise || p_fall) begin
            loss_q <= 16'h0000;
            on_pclk_q <= ~no_pclk;
        end else if (loss_q == LOSS_MAX - 16'h0001) begin
            on_pclk_q <= 1'b0;
        end else begin
            loss_q <= loss_q + 16'h0001;
        end
        if (no_pclk) begin
            on_pclk_q <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Word packing per clock division
// ----------------------------------------------------------------
wire ten = (mode_q == `CLSC_MODE_TEN);
wire [5:0] word_w = ten ? `CLSC_WORD_TEN : `CLSC_WORD_TWELVE;
reg [5:0] pay_w;
always @* begin
    case (mode_q)
        `CLSC_MODE_HF12: pay_w = `CLSC_PAY_HF12;
        `CLSC_MODE_TEN: pay_w = `CLSC_PAY_TEN;
        default: pay_w = `CLSC_PAY_LF12;
    endcase
end

wire [13:0] pix_word = ten ?
    {2'b00, pin_s2_q[13:12], pin_s2_q[9:0]} : pin_s2_q[13:0];
reg [47:0] acc_q;
reg [5:0] cnt_q;
wire [47:0] acc_sum = acc_q | ({34'h0, pix_word} << cnt_q);
wire [5:0] cnt_sum = cnt_q + word_w;
wire take = on_pclk_q && p_edge && !pd_active;
wire emit_pix = take && (cnt_sum >= pay_w);
wire emit_osc = !on_pclk_q && osc_tick && !pd_active;
wire [23:0] pay_mask = ~(24'hFFFFFF << pay_w);
wire [23:0] payload = emit_pix ? (acc_sum[23:0] & pay_mask) : 24'h000000;

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        acc_q <= 48'h0;
        cnt_q <= 6'h00;
    end else if (!on_pclk_q || pd_active) begin
        acc_q <= 48'h0;
        cnt_q <= 6'h00;
    end else if (take) begin
        if (emit_pix) begin
            acc_q <= acc_sum >> pay_w;
            cnt_q <= cnt_sum - pay_w;
        end else begin
            acc_q <= acc_sum;
            cnt_q <= cnt_sum;
        end
    end
end

// ----------------------------------------------------------------
// Frame build: scramble, balance, parity
// ----------------------------------------------------------------
reg [15:0] lfsr_q;
reg signed [7:0] disp_q;
wire [25:0] raw26 = {ctrl_tx_bit, ~on_pclk_q,
    payload ^ {lfsr_q[7:0], lfsr_q}};
wire [4:0] ones = ones26(raw26);
wire signed [7:0] word_disp = $signed({2'b00, ones, 1'b0}) - 8'sd26;
wire flip = (disp_q >= 0) ? (word_disp > 0) : (word_disp < 0);
wire [25:0] bal26 = flip ? ~raw26 : raw26;
wire [26:0] body = {flip, bal26};
wire emit = emit_pix || emit_osc;

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        lfsr_q <= `CLSC_LFSR_SEED;
        disp_q <= 8'sd0;
        frame_word_q <= 28'hFFFFFFF;
        frame_valid_q <= 1'b0;
        link_enable_q <= 1'b0;
    end else begin
        link_enable_q <= ~pd_active;
        frame_valid_q <= emit;
        if (pd_active) begin
            frame_word_q <= 28'hFFFFFFF;
            disp_q <= 8'sd0;
            lfsr_q <= `CLSC_LFSR_SEED;
        end else if (emit) begin
            frame_word_q <= {^body, body};
            disp_q <= flip ? disp_q - word_disp : disp_q + word_disp;
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^
                lfsr_q[12] ^ lfsr_q[10]};
        end
    end
end

// ----------------------------------------------------------------
// General purpose outputs
// ----------------------------------------------------------------
reg xdiv_q;
wire [3:0] gpo_sel = gpo_cfg_q[`CLSC_GPO_SRC_LSB +: 4];
wire [3:0] gpo_loc = gpo_cfg_q[`CLSC_GPO_LOCAL_LSB +: 4];
wire [3:0] gpo_val = (gpo_sel & remote_q) | (~gpo_sel & gpo_loc);

always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        xdiv_q <= 1'b0;
        general_output_pin_q <= 4'h0;
        general_output_oe_q <= 4'h0;
    end else begin
        if (ext_mode && xclk_rise) begin
            xdiv_q <= ~xdiv_q;
        end
        if (ext_mode) begin
            general_output_pin_q <= {1'b0, xdiv_q, gpo_val[1:0]};
            general_output_oe_q <= 4'h7;
        end else begin
            general_output_pin_q <= gpo_val;
            general_output_oe_q <= 4'hF;
        end
    end
end

endmodule // clsc_serializer

// ### hw/clsc_regs.vh
// Register offsets, field positions, reset values and timing in ns
`ifndef CLSC_REGS_VH
`define CLSC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CLSC_ADDR_CONFIG 8'h03
`define CLSC_ADDR_MODE 8'h04
`define CLSC_ADDR_CRC_CNT_FIRST 8'h0A
`define CLSC_ADDR_CRC_CNT_SECOND 8'h0B
`define CLSC_ADDR_GPO_CFG 8'h0D
`define CLSC_ADDR_STATUS 8'h0E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CLSC_CFG_EDGE_BIT 0
`define CLSC_CFG_NO_PCLK_BIT 1
`define CLSC_GPO_SRC_LSB 0
`define CLSC_GPO_LOCAL_LSB 4

// ----------------------------------------------------------------
// Modes and reset values
// ----------------------------------------------------------------
`define CLSC_MODE_LF12 2'h0
`define CLSC_MODE_HF12 2'h1
`define CLSC_MODE_TEN 2'h2
`define CLSC_CONFIG_RST 8'h01
`define CLSC_MODE_RST 2'h0
`define CLSC_GPO_CFG_RST 8'h00
`define CLSC_LFSR_SEED 16'hACE1

// ----------------------------------------------------------------
// Frame layout and payload widths
// ----------------------------------------------------------------
`define CLSC_FRAME_BITS 28
`define CLSC_PAY_LF12 6'd14
`define CLSC_PAY_HF12 6'd21
`define CLSC_PAY_TEN 6'd24
`define CLSC_WORD_TWELVE 6'd14
`define CLSC_WORD_TEN 6'd12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLSC_CLK_PERIOD_NS 8
`define CLSC_PCLK_LOSS_NS 1000
`define CLSC_OSC_FRAME_NS 40

`endif

// ### tb/clsc_checker_properties.sv
// Concurrent checks on the serializer core ports
`timescale 1ns/100ps
module clsc_checker (
    input wire clk,
    input wire reset_n,
    input wire power_down_n,
    input wire ext_osc_mode,
    input wire general_output_three_in,
    input wire reg_read,
    input wire [7:0] reg_rdata_q,
    input wire [27:0] frame_word_q,
    input wire frame_valid_q,
    input wire link_enable_q,
    input wire [3:0] general_output_pin_q,
    input wire [3:0] general_output_oe_q
);
    // ----
    // Checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_off_word_high: assert property (!link_enable_q |-> &frame_word_q)
        else $error("frame word not all ones while link is off");
    chk_off_no_frame: assert property (!link_enable_q |-> !frame_valid_q)
        else $error("frame pulse while link is off");
    chk_pd_link_off: assert property (!power_down_n [*5] |-> !link_enable_q)
        else $error("link still on in power down");
    chk_pd_link_on: assert property (power_down_n [*8] |-> link_enable_q)
        else $error("link off while powered up");
    chk_frame_parity: assert property (frame_valid_q |-> !(^frame_word_q))
        else $error("frame parity bit wrong");
    chk_frame_gap: assert property (frame_valid_q |=> !frame_valid_q)
        else $error("frame pulses too close");
    chk_read_idle: assert property (!reg_read |=> reg_rdata_q == 8'h00)
        else $error("read data outside its cycle");
    chk_ext_pin_input: assert property (ext_osc_mode [*5] |-> !general_output_oe_q[3])
        else $error("output three driven in external clock mode");
    chk_ext_half_clock: assert property (ext_osc_mode [*6] ##0
        $rose(general_output_three_in) |-> ##[1:5] $changed(general_output_pin_q[2]))
        else $error("output two does not follow external clock");
endmodule // clsc_checker
bind clsc_serializer clsc_checker clsc_checker_inst (.clk(clk), .reset_n(reset_n),
    .power_down_n(power_down_n), .ext_osc_mode(ext_osc_mode),
    .general_output_three_in(general_output_three_in), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .frame_word_q(frame_word_q),
    .frame_valid_q(frame_valid_q), .link_enable_q(link_enable_q),
    .general_output_pin_q(general_output_pin_q),
    .general_output_oe_q(general_output_oe_q));

// ### tb/clsc_deser_model.sv
// Far end stand-in: frame parity check and back channel source
`timescale 1ns/100ps
module clsc_deser_model (
    input wire clk,
    input wire reset_n,
    input wire frame_valid,
    input wire [27:0] frame_word,
    input wire send,
    input wire corrupt,
    input wire [3:0] remote_pins,
    input wire ext_mode,
    input wire rx_strobe_edge_select,
    output wire [27:0] rx_word,
    output reg bc_valid,
    output reg [7:0] bc_data,
    output reg [3:0] bc_crc,
    output reg [7:0] parity_err_q,
    output reg pass_ok_q
);
    // ----
    // Back channel and parity
    // ----
    function automatic [3:0] crc4(input [7:0] d);
        integer i;
        begin
            crc4 = 4'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                crc4 = {crc4[2:0], 1'b0} ^ ((crc4[3] ^ d[i]) ? 4'h3 : 4'h0);
            end
        end
    endfunction
    wire [7:0] fwd = {4'h0, remote_pins[3:2] & {2{~ext_mode}},
        remote_pins[1:0]};
    reg [27:0] rx_pos_q, rx_neg_q;
    always @(posedge clk) begin
        if (frame_valid) begin
            rx_pos_q <= frame_word;
        end
    end
    always @(negedge clk) begin
        if (frame_valid) begin
            rx_neg_q <= frame_word;
        end
    end
    assign rx_word = rx_strobe_edge_select ? rx_pos_q : rx_neg_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_err_q <= 8'h00;
            pass_ok_q <= 1'b1;
            bc_valid <= 1'b0;
            bc_data <= 8'h00;
            bc_crc <= 4'h0;
        end else begin
            if (frame_valid && ^frame_word) begin
                parity_err_q <= parity_err_q + 8'h01;
                pass_ok_q <= 1'b0;
            end
            bc_valid <= send;
            bc_data <= send ? fwd : ~bc_data;
            bc_crc <= send ? crc4(fwd) ^ {3'h0, corrupt}
                : ~bc_crc;
        end
    end
endmodule // clsc_deser_model

// ### tb/test_camera_link_serializer_core.sv
// Self-checking bench for the serializer core
`timescale 1ns/100ps
module test_camera_link_serializer_core;
    reg clk = 0, reset_n = 0, pixel_clock = 0, pclk_on = 0;
    reg [11:0] pixel_data = 12'h000;
    reg line_sync = 0, frame_sync = 0, power_down_n = 1, ext_osc_mode = 0;
    reg gp3_in = 0, ctrl_tx_bit = 0, reg_write = 0, reg_read = 0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, m;
    reg send = 0, corrupt = 0, rx_sel = 1;
    reg [3:0] rpins = 4'h0;
    wire [7:0] rdata, bcd, perr;
    wire [27:0] fword, rx_word;
    wire fvalid, link_en, bcv, pass_ok;
    wire [3:0] general_output_pin, gpo_oe, bcc;
    integer err_total = 0, n_tests = 0, cyc = 0, fcnt = 0, c0;
    clsc_serializer #(.LOSS_NS(200)) clsc_serializer_inst (.clk(clk),
        .reset_n(reset_n), .pixel_clock(pixel_clock), .pixel_data(pixel_data),
        .line_sync(line_sync), .frame_sync(frame_sync),
        .power_down_n(power_down_n), .ext_osc_mode(ext_osc_mode),
        .general_output_three_in(gp3_in), .ctrl_tx_bit(ctrl_tx_bit),
        .bc_valid(bcv), .bc_data(bcd), .bc_crc(bcc), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_q(rdata), .frame_word_q(fword), .frame_valid_q(fvalid),
        .link_enable_q(link_en), .general_output_pin_q(general_output_pin),
        .general_output_oe_q(gpo_oe));
    clsc_deser_model clsc_deser_model_inst (.clk(clk), .reset_n(reset_n),
        .frame_valid(fvalid), .frame_word(fword), .send(send),
        .corrupt(corrupt), .remote_pins(rpins), .ext_mode(ext_osc_mode),
        .rx_strobe_edge_select(rx_sel), .rx_word(rx_word), .bc_valid(bcv),
        .bc_data(bcd), .bc_crc(bcc), .parity_err_q(perr),
        .pass_ok_q(pass_ok));
    // ----
    // Clocks, imager and timeout
    // ----
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fvalid) begin
            fcnt <= fcnt + 1;
        end
        if (pclk_on && cyc % 4 == 3) begin
            pixel_clock <= ~pixel_clock;
            if (pixel_clock) begin
                pixel_data <= pixel_data + 12'h015;
                line_sync <= pixel_data[11];
                frame_sync <= pixel_data[10];
                ctrl_tx_bit <= ~ctrl_tx_bit;
            end
        end
        if (ext_osc_mode && cyc % 8 == 0) begin
            gp3_in <= ~gp3_in;
        end
        if (cyc == 20000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    // ----
    // Tasks
    // ----
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clk);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clk);
            reg_read <= 1'b0;
            #1 chk(rdata, e);
        end
    endtask
    task bc(input [3:0] p, input c);
        begin
            @(posedge clk);
            rpins <= p;
            corrupt <= c;
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task win(input [31:0] n, input [31:0] e);
        begin
            repeat (64) @(posedge clk);
            c0 = fcnt;
            repeat (n) @(posedge clk);
            chk(fcnt - c0, e);
            #1 if (!fvalid) chk(rx_word, fword);
        end
    endtask
    task give_verdict;
        begin
            $display("checks=%0d mismatches=%0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h03, 8'h01);
        rd(8'h04, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h00);
        rd(8'h20, 8'h00);
        $display("reset values done");
        bc(4'h0, 1);
        bc(4'h0, 1);
        bc(4'h0, 1);
        rd(8'h0A, 8'h03);
        rd(8'h0B, 8'h00);
        wr(8'h0A, 8'h00);
        rd(8'h0A, 8'h00);
        $display("error count done");
        wr(8'h0D, 8'h53);
        bc(4'hA, 0);
        chk(general_output_pin, 4'h6);
        chk(gpo_oe, 4'hF);
        bc(4'h5, 1);
        chk(general_output_pin, 4'h6);
        bc(4'h5, 0);
        chk(general_output_pin, 4'h5);
        $display("outputs done");
        pclk_on <= 1'b1;
        repeat (100) @(posedge clk);
        rd(8'h0E, 8'h01);
        for (m = 0; m < 3; m = m + 1) begin
            wr(8'h04, m);
            win(96, m == 0 ? 12 : (m == 1 ? 8 : 6));
        end
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h00);
        rx_sel <= 1'b0;
        win(96, 12);
        pclk_on <= 1'b0;
        win(100, 20);
        rd(8'h0E, 8'h00);
        wr(8'h03, 8'h03);
        pclk_on <= 1'b1;
        repeat (64) @(posedge clk);
        rd(8'h0E, 8'h00);
        wr(8'h03, 8'h01);
        repeat (64) @(posedge clk);
        rd(8'h0E, 8'h01);
        $display("framing done");
        @(posedge clk);
        pclk_on <= 1'b0;
        power_down_n <= 1'b0;
        repeat (40) @(posedge clk);
        #1 chk(link_en, 0);
        chk(fword, 28'hFFFFFFF);
        rd(8'h0E, 8'h02);
        @(posedge clk);
        power_down_n <= 1'b1;
        ext_osc_mode <= 1'b1;
        repeat (40) @(posedge clk);
        #1 chk(gpo_oe[3], 0);
        chk(link_en, 1);
        rd(8'h0E, 8'h04);
        bc(4'hF, 0);
        chk(general_output_pin[1:0], 2'h3);
        ext_osc_mode <= 1'b0;
        chk(perr, 0);
        chk(pass_ok, 1);
        $display("power and clock modes done");
        give_verdict;
    end
endmodule // test_camera_link_serializer_core
